// ### hw/pdc_device_control.sv
// Purpose: port device control register bank with wishbone slave
// Assumes: single clock, event inputs come from logic on clk
// Notes:   one wait state; ack follows a request by one cycle
`timescale 1ns/1ps
`default_nettype none
module pdc_device_control (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [pdc_pkg::ADR_W-1:0]     adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [pdc_pkg::DAT_W-1:0]     dat_i,
  output logic [pdc_pkg::DAT_W-1:0]          dat_o,
  output logic                               ack_o,
  // error events and gated reports
  input  wire logic                          corr_err_event,
  input  wire logic                          nonfatal_err_event,
  input  wire logic                          fatal_err_event,
  input  wire logic                          unsup_req_event,
  output logic                               corr_err_report,
  output logic                               nonfatal_err_report,
  output logic                               fatal_err_report,
  output logic                               unsup_req_report,
  // payload and tag controls
  output logic [12:0]                        max_payload_bytes,
  output logic                               extended_tag_enable,
  input  wire logic                          tag_take,
  output logic [7:0]                         seq_tag,
  // forwarded transaction attributes
  input  wire logic                          fwd_no_snoop_in,
  input  wire logic [2:0]                    fwd_read_size_in,
  output logic                               fwd_no_snoop_out,
  output logic [2:0]                         fwd_read_size_out
);
  import pdc_pkg::*;

  // reset release synchroniser
  logic rst_meta_ff;
  logic rst_n_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_s     <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_s     <= rst_meta_ff;
    end
  end

  // bus slave state
  pdc_bus_state_t    state_ff;
  pdc_bus_state_t    nxt_state;
  logic              ack_ff;
  logic              nxt_ack;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              req;
  logic              wr_now;

  // register state
  logic [15:0]       ctrl_ff;
  logic [15:0]       nxt_ctrl;
  logic [2:0]        cap_ff;
  logic [2:0]        nxt_cap;
  logic              seq_ff;
  logic              nxt_seq;
  logic [15:0]       wmask;
  logic [15:0]       ctrl_wr;

  // derived state
  logic [2:0]        mps_code;
  logic [2:0]        eff_code;
  logic              over_cap;
  logic [7:0]        tag_w;
  logic [15:0]       stat_word;

  assign req    = cyc_i & stb_i;
  // a write lands on the edge at which the master sees ack
  assign wr_now = ack_ff & req & we_i;

  always_comb begin
    nxt_state = state_ff;
    nxt_ack   = 1'b0;
    case (state_ff)
      PDC_BUS_IDLE: begin
        if (req) begin
          nxt_state = PDC_BUS_ACK;
          nxt_ack   = 1'b1;
        end
      end
      PDC_BUS_ACK: begin
        nxt_state = PDC_BUS_IDLE;
      end
      default: begin
        nxt_state = PDC_BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    mps_code = ctrl_ff[MPS_LSB +: 3];
    // reserved codes six and seven fall back to the smallest size
    eff_code = (mps_code > MPS_MAX_CODE) ? 3'h0 : mps_code;
    // software is trusted to stay within capability; we only flag it
    over_cap = (eff_code > cap_ff);
    stat_word = 16'h0000;
    stat_word[STAT_CODE_LSB +: 3] = eff_code;
    stat_word[STAT_OVER_BIT]      = over_cap;
    stat_word[STAT_TAG_LSB +: 8]  = tag_w;
  end

  // read mux; unmapped addresses answer with zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (state_ff == PDC_BUS_IDLE && req && !we_i) begin
      case (adr_i)
        DEV_CTRL_ADR:  nxt_rdata = {16'h0000,
                                    ctrl_ff & DEV_CTRL_RW};
        DEV_CAP_ADR:   nxt_rdata = {29'h0000_0000, cap_ff};
        TL_CTRL_ADR:   nxt_rdata = {31'h0000_0000, seq_ff};
        PORT_STAT_ADR: nxt_rdata = {16'h0000, stat_word};
        default:       nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register writes, byte lanes 0 and 1 only
  always_comb begin
    wmask   = {{8{sel_i[1]}}, {8{sel_i[0]}}} & DEV_CTRL_RW;
    ctrl_wr = (ctrl_ff & ~wmask) | (dat_i[15:0] & wmask);
    nxt_ctrl = ctrl_ff;
    nxt_cap  = cap_ff;
    nxt_seq  = seq_ff;
    if (wr_now) begin
      case (adr_i)
        DEV_CTRL_ADR: begin
          // ro fields 4, 9..15 stay zero through the mask
          nxt_ctrl = ctrl_wr;
        end
        DEV_CAP_ADR: begin
          if (sel_i[0]) begin
            nxt_cap = dat_i[2:0];
          end
        end
        TL_CTRL_ADR: begin
          if (sel_i[0]) begin
            nxt_seq = dat_i[SEQ_BIT];
          end
        end
        default: begin
          nxt_ctrl = ctrl_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_ff <= PDC_BUS_IDLE;
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff  <= DEV_CTRL_RESET;
      cap_ff   <= CAP_RESET;
      seq_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
      ctrl_ff  <= nxt_ctrl;
      cap_ff   <= nxt_cap;
      seq_ff   <= nxt_seq;
    end
  end

  // port side outputs, each one flop deep
  logic        corr_ff;
  logic        nonfatal_ff;
  logic        fatal_ff;
  logic        unsup_ff;
  logic [12:0] payload_ff;
  logic        ns_ff;
  logic [2:0]  rsize_ff;
  logic        nxt_corr;
  logic        nxt_nonfatal;
  logic        nxt_fatal;
  logic        nxt_unsup;
  logic [12:0] nxt_payload;

  always_comb begin
    nxt_corr     = corr_err_event & ctrl_ff[CER_BIT];
    nxt_nonfatal = nonfatal_err_event & ctrl_ff[NFER_BIT];
    nxt_fatal    = fatal_err_event & ctrl_ff[FER_BIT];
    nxt_unsup    = unsup_req_event & ctrl_ff[URR_BIT];
    nxt_payload  = PAYLOAD_BASE << eff_code;
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      corr_ff     <= 1'b0;
      nonfatal_ff <= 1'b0;
      fatal_ff    <= 1'b0;
      unsup_ff    <= 1'b0;
      payload_ff  <= PAYLOAD_BASE;
      ns_ff       <= 1'b0;
      rsize_ff    <= 3'h0;
    end else begin
      corr_ff     <= nxt_corr;
      nonfatal_ff <= nxt_nonfatal;
      fatal_ff    <= nxt_fatal;
      unsup_ff    <= nxt_unsup;
      payload_ff  <= nxt_payload;
      // pass-through attributes are never altered here
      ns_ff       <= fwd_no_snoop_in;
      rsize_ff    <= fwd_read_size_in;
    end
  end

  // extended tag sets the debug tag counter range and drives extended_tag_enable
  pdc_seq_tag u_seq_tag (
    .clk        (clk),
    .rst_n      (rst_n_s),
    .seq_enable (seq_ff),
    .ext_tag    (ctrl_ff[ETAG_BIT]),
    .tag_take   (tag_take),
    .tag        (tag_w)
  );

  assign dat_o               = rdata_ff;
  assign ack_o               = ack_ff;
  assign corr_err_report     = corr_ff;
  assign nonfatal_err_report = nonfatal_ff;
  assign fatal_err_report    = fatal_ff;
  assign unsup_req_report    = unsup_ff;
  assign max_payload_bytes   = payload_ff;
  assign extended_tag_enable = ctrl_ff[ETAG_BIT];
  assign seq_tag             = tag_w;
  assign fwd_no_snoop_out    = ns_ff;
  assign fwd_read_size_out   = rsize_ff;

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  corr_gate_a: assert property (
    corr_err_report == $past(corr_err_event && ctrl_ff[CER_BIT]))
    else $error("correctable report not gated by enable");
  nonfatal_gate_a: assert property (
    $past(nonfatal_err_event) && !$past(ctrl_ff[NFER_BIT])
      |-> !nonfatal_err_report)
    else $error("non-fatal report leaked while disabled");
  fatal_gate_a: assert property (
    fatal_err_event && ctrl_ff[FER_BIT] |=> fatal_err_report)
    else $error("fatal report missing");
  unsup_gate_a: assert property (
    unsup_req_report |-> $past(unsup_req_event && ctrl_ff[URR_BIT]))
    else $error("unsupported request report without cause");
  ro_bits_zero_a: assert property (
    ack_o && !we_i && adr_i == DEV_CTRL_ADR
      |-> (dat_o[31:0] & ~{16'h0000, DEV_CTRL_RW}) == 32'h0000_0000)
    else $error("read-only control bits read nonzero");
  payload_map_a: assert property (
    ctrl_ff[MPS_LSB +: 3] <= MPS_MAX_CODE
      |=> max_payload_bytes == 13'(PAYLOAD_BASE << $past(mps_code)))
    else $error("payload size does not match code");
  payload_rsvd_a: assert property (
    ctrl_ff[MPS_LSB +: 3] > MPS_MAX_CODE |=> max_payload_bytes == 13'h0080)
    else $error("reserved payload code not treated as 128");
  etag_write_a: assert property (
    wr_now && adr_i == DEV_CTRL_ADR && sel_i[1]
      |=> extended_tag_enable == $past(dat_i[ETAG_BIT]))
    else $error("extended tag write lost");
  ns_pass_a: assert property (
    fwd_no_snoop_out == $past(fwd_no_snoop_in))
    else $error("no snoop attribute altered");
  rsize_pass_a: assert property (
    ##1 fwd_read_size_out == $past(fwd_read_size_in))
    else $error("read size altered");
  cap_reset_a: assert property (
    $rose(rst_n_s) |-> cap_ff == 3'h4)
    else $error("capability not code four after reset");
  ro_write_a: assert property (
    1'b1 |-> (ctrl_ff & ~DEV_CTRL_RW) == 16'h0000)
    else $error("read-only control bit became set");
  nonfatal_set_a: assert property (
    nonfatal_err_event && ctrl_ff[NFER_BIT] |=> nonfatal_err_report)
    else $error("non-fatal report missing");
  unsup_set_a: assert property (
    unsup_req_event && ctrl_ff[URR_BIT] |=> unsup_req_report)
    else $error("unsupported request report missing");
  seq_off_zero_a: assert property (
    !seq_ff |=> seq_tag == 8'h00)
    else $error("debug tag nonzero with switch clear");
  unmapped_write_a: assert property (
    wr_now && adr_i != DEV_CTRL_ADR |=> ctrl_ff == $past(ctrl_ff))
    else $error("control changed by another address");

  cov_ctrl_write_c: cover property (wr_now && adr_i == DEV_CTRL_ADR);
  cov_rsvd_code_c:  cover property (mps_code == 3'h7);
  cov_over_cap_c:   cover property (over_cap);
  cov_fatal_rep_c:  cover property (fatal_err_report);
endmodule : pdc_device_control
`default_nettype wire

// ### hw/pdc_pkg.sv
// Purpose: constants for the port device control register bank
// Assumes: 32-bit classic wishbone, byte addresses, 50 MHz core clock
// Notes:   the control word sits in the low 16 bits of its bus word
package pdc_pkg;
  localparam int unsigned ADR_W          = 12;
  localparam int unsigned DAT_W          = 32;
  // register byte addresses
  localparam logic [11:0] DEV_CTRL_ADR   = 12'h048;
  localparam logic [11:0] DEV_CAP_ADR    = 12'h100;
  localparam logic [11:0] TL_CTRL_ADR    = 12'h104;
  localparam logic [11:0] PORT_STAT_ADR  = 12'h108;
  // device control fields
  localparam int unsigned CER_BIT        = 0;
  localparam int unsigned NFER_BIT       = 1;
  localparam int unsigned FER_BIT        = 2;
  localparam int unsigned URR_BIT        = 3;
  localparam int unsigned MPS_LSB        = 5;
  localparam int unsigned ETAG_BIT       = 8;
  localparam logic [15:0] DEV_CTRL_RESET = 16'h0000;
  localparam logic [15:0] DEV_CTRL_RW    = 16'h01EF;
  // payload size encoding
  localparam logic [2:0]  MPS_MAX_CODE   = 3'h5;
  localparam logic [12:0] PAYLOAD_BASE   = 13'h0080;
  // capability and transaction layer control
  localparam logic [2:0]  CAP_RESET      = 3'h4;
  localparam int unsigned SEQ_BIT        = 0;
  // port status fields
  localparam int unsigned STAT_CODE_LSB  = 0;
  localparam int unsigned STAT_OVER_BIT  = 3;
  localparam int unsigned STAT_TAG_LSB   = 8;
  // debug tag limits
  localparam logic [7:0]  TAG_LIMIT_STD  = 8'h1F;
  localparam logic [7:0]  TAG_LIMIT_EXT  = 8'hFF;

  typedef enum logic [1:0] {
    PDC_BUS_IDLE = 2'b01,
    PDC_BUS_ACK  = 2'b10
  } pdc_bus_state_t;
endpackage : pdc_pkg

// ### hw/pdc_seq_tag.sv
// Purpose: sequential debug tag generator
// Assumes: tag_take is a one-cycle pulse from logic on clk
// Notes:   output holds zero while the debug switch is off
`timescale 1ns/1ps
`default_nettype none
module pdc_seq_tag (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       seq_enable,
  input  wire logic       ext_tag,
  input  wire logic       tag_take,
  output logic [7:0]      tag
);
  import pdc_pkg::*;

  logic [7:0] tag_ff;
  logic [7:0] nxt_tag;
  logic [7:0] limit;

  always_comb begin
    limit   = ext_tag ? TAG_LIMIT_EXT : TAG_LIMIT_STD;
    nxt_tag = tag_ff;
    if (!seq_enable) begin
      nxt_tag = 8'h00;
    end else if (tag_ff > limit) begin
      // extended range switched off mid-run: restart in range
      nxt_tag = 8'h00;
    end else if (tag_take) begin
      nxt_tag = (tag_ff == limit) ? 8'h00 : tag_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_ff <= 8'h00;
    end else begin
      tag_ff <= nxt_tag;
    end
  end

  assign tag = tag_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  tag_std_range_a: assert property (
    seq_enable && !ext_tag && $past(seq_enable && !ext_tag)
      |-> tag <= TAG_LIMIT_STD)
    else $error("tag left 0..31 range");
  tag_wrap_a: assert property (
    seq_enable && tag_take && tag == limit |=> tag == 8'h00)
    else $error("tag did not wrap at limit");
  cov_tag_wrap_c: cover property (
    seq_enable && tag_take && ext_tag && tag == TAG_LIMIT_EXT);
endmodule : pdc_seq_tag
`default_nettype wire

// ### dv/pdc_device_control_tb.sv
// Purpose: self-checking bench for the port device control register bank
// Assumes: one wait state slave, outputs settled by the falling edge
// Notes:   per-cycle results are noted at drive time, checked one cycle on
`timescale 1ns/1ps
`default_nettype none
module pdc_device_control_tb;
  import pdc_pkg::*;
  typedef struct packed {
    logic [3:0] rep;
    logic       ns;
    logic [2:0] rs;
    logic [7:0] tag;
  } pdc_note_t;
  logic        clk;
  logic        reset_n;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [3:0]  ev;
  logic [3:0]  rep;
  logic [12:0] max_payload_bytes;
  logic        extended_tag_enable;
  logic        tag_take;
  logic [7:0]  seq_tag;
  logic        fwd_no_snoop_in;
  logic [2:0]  fwd_read_size_in;
  logic        fwd_no_snoop_out;
  logic [2:0]  fwd_read_size_out;
  logic [31:0] dq[$];
  pdc_note_t   nq[$];
  logic [7:0]  tag_m;
  logic [31:0] r;
  logic [12:0] pay_x;
  pdc_note_t   got_n;
  pdc_note_t   exp_n;
  int          seed;
  int          seen;
  int          mismatches;
  int          checks;

  pdc_device_control dut (
    .clk                 (clk),
    .reset_n             (reset_n),
    .cyc_i               (cyc_i),
    .stb_i               (stb_i),
    .we_i                (we_i),
    .adr_i               (adr_i),
    .sel_i               (sel_i),
    .dat_i               (dat_i),
    .dat_o               (dat_o),
    .ack_o               (ack_o),
    .corr_err_event      (ev[0]),
    .nonfatal_err_event  (ev[1]),
    .fatal_err_event     (ev[2]),
    .unsup_req_event     (ev[3]),
    .corr_err_report     (rep[0]),
    .nonfatal_err_report (rep[1]),
    .fatal_err_report    (rep[2]),
    .unsup_req_report    (rep[3]),
    .max_payload_bytes   (max_payload_bytes),
    .extended_tag_enable (extended_tag_enable),
    .tag_take            (tag_take),
    .seq_tag             (seq_tag),
    .fwd_no_snoop_in     (fwd_no_snoop_in),
    .fwd_read_size_in    (fwd_read_size_in),
    .fwd_no_snoop_out    (fwd_no_snoop_out),
    .fwd_read_size_out   (fwd_read_size_out)
  );

  always #10 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic bad(input string msg);
    mismatches++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) bad($sformatf("word %h want %h", got, exp));
  endtask : cmp_word

  task automatic cmp_pay(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) bad($sformatf("payload %h want %h", got, exp));
  endtask : cmp_pay

  task automatic cmp_note(input pdc_note_t got, input pdc_note_t exp);
    checks++;
    if (got !== exp) bad($sformatf("cycle %h want %h", got, exp));
  endtask : cmp_note

  // holds the whole request until ack is sampled, then idles one cycle
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      bad("no ack");
      report_and_stop();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    bus(1'b1, a, s, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    dq.push_back(exp);
    bus(1'b0, a, 4'hF, 32'h0000_0000);
  endtask : rd

  // random events, tag pulses and forwarded attributes every cycle
  task automatic traffic(input int n, input logic [3:0] en, input logic ext);
    pdc_note_t e;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      r = $random(seed);
      e.rep = r[3:0] & en;
      e.ns  = r[6];
      e.rs  = r[9:7];
      if (r[5:4] != 2'b00) begin
        tag_m = (tag_m == (ext ? TAG_LIMIT_EXT : TAG_LIMIT_STD)) ?
                8'h00 : tag_m + 8'h01;
      end
      e.tag = tag_m;
      ev               <= r[3:0];
      tag_take         <= (r[5:4] != 2'b00);
      fwd_no_snoop_in  <= r[6];
      fwd_read_size_in <= r[9:7];
      nq.push_back(e);
    end
    @(posedge clk);
    ev       <= 4'h0;
    tag_take <= 1'b0;
  endtask : traffic

  // read data is taken at the edge where ack is sampled high
  always @(posedge clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (dq.size() == 0) bad("read not expected");
      else cmp_word(dat_o, dq.pop_front());
    end
  end

  always @(negedge clk) begin
    if (seen > 0) begin
      got_n = {rep, fwd_no_snoop_out, fwd_read_size_out, seq_tag};
      exp_n = nq.pop_front();
      cmp_note(got_n, exp_n);
    end
    seen = nq.size();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {cyc_i, stb_i, we_i, tag_take, fwd_no_snoop_in} = 5'h00;
    {adr_i, sel_i, dat_i, ev, fwd_read_size_in} = '0;
    seed = 20626;
    seen = 0;
    tag_m = 8'h00;
    mismatches = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_pay(max_payload_bytes, 13'h0080);
    rd(DEV_CTRL_ADR, 32'h0000_0000);
    rd(DEV_CAP_ADR, 32'h0000_0004);
    rd(12'h200, 32'h0000_0000);
    wr(DEV_CTRL_ADR, 4'hF, 32'hFFFF_FFFF);
    rd(DEV_CTRL_ADR, 32'h0000_01EF);
    cmp_word({31'h0, extended_tag_enable}, 32'h0000_0001);
    wr(DEV_CTRL_ADR, 4'h1, 32'h0000_0000);
    rd(DEV_CTRL_ADR, 32'h0000_0100);
    wr(12'h200, 4'hF, 32'hFFFF_FFFF);
    rd(12'h200, 32'h0000_0000);
    // capability raised first so that code five stays a legal setting
    wr(DEV_CAP_ADR, 4'h1, 32'h0000_0005);
    rd(DEV_CAP_ADR, 32'h0000_0005);
    for (int c = 0; c < 8; c++) begin
      wr(DEV_CTRL_ADR, 4'h3, {24'h0, c[2:0], 5'h00});
      rd(DEV_CTRL_ADR, {24'h0, c[2:0], 5'h00});
      pay_x = (c < 6) ? 13'(PAYLOAD_BASE << c) : PAYLOAD_BASE;
      cmp_pay(max_payload_bytes, pay_x);
      rd(PORT_STAT_ADR, {28'h0, 1'b0, (c < 6) ? c[2:0] : 3'h0});
    end
    wr(TL_CTRL_ADR, 4'h1, 32'h0000_0001);
    rd(TL_CTRL_ADR, 32'h0000_0001);
    wr(DEV_CTRL_ADR, 4'h3, 32'h0000_000F);
    traffic(300, 4'hF, 1'b0);
    r = $random(seed);
    wr(DEV_CTRL_ADR, 4'h3, {23'h0, 1'b1, 4'h0, r[3:0]});
    cmp_word({31'h0, extended_tag_enable}, 32'h0000_0001);
    traffic(700, r[3:0], 1'b1);
    wr(DEV_CTRL_ADR, 4'h3, 32'h0000_0100);
    traffic(100, 4'h0, 1'b1);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : pdc_device_control_tb
`default_nettype wire
